/* File: aspc_conv_model.sv */
// converter model: answers each start with one done pulse after a settable delay
`timescale 1ns/1ps
`default_nettype none

module aspc_conv_model (
    input  wire logic                   clock,
    input  wire logic                   reset,
    input  wire aspc_pkg::aspc_conv_req_type conv_req,
    input  wire logic [3:0]             lat,
    input  wire logic [11:0]            base,
    output logic                        conv_done,
    output logic [11:0]                 conv_data
);
    import aspc_pkg::*;

    logic       busy;
    logic [3:0] cnt;
    logic [2:0] ch;

    // result is base plus channel so the bench can predict every register
    always_ff @(posedge clock) begin
        if (reset) begin
            busy      <= 1'b0;
            cnt       <= 4'h0;
            ch        <= 3'h0;
            conv_done <= 1'b0;
            conv_data <= 12'h000;
        end else begin
            conv_done <= 1'b0;
            // data toggles outside the done pulse, never holds the old result
            conv_data <= ~conv_data;
            if (conv_req.start) begin
                busy <= 1'b1;
                cnt  <= lat;
                ch   <= conv_req.channel;
            end else if (busy && cnt == 4'h0) begin
                busy      <= 1'b0;
                conv_done <= 1'b1;
                conv_data <= base + {9'h000, ch};
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: aspc_ctrl.sv */
// converter signal path control: register file, pass sequencer, clock and rate timers
// Overview of operation
// R1 - reference and amplifier powered down after reset
// R2 - control bit 0 enables reference generator
// R3 - amplifier register bit 0 enables amplifier
// R4 - control bit 7 picks reference source
// R5 - control bit 6 picks single or four channels
// R6 - writing control bit 5 starts one pass
// R7 - control bit 4 low holds converter down
// R8 - writing control bit 3 clears done flag
// R9 - control bit 2 gates interrupt output
// R10 - control bit 1 enables timed repeated passes
// R11 - status bit 0 set when pass ends
// R12 - mux register bit 7 picks correction order
// R13 - four-channel mode uses select bit 2 only
// R14 - software programs all three select bits
// R15 - mux bits 3..0 power input buffers, low off
// R16 - results split low byte, high nibble
// R17 - result registers hold latest conversion
// R18 - three bytes form 24-bit rate word
// R19 - software aims divider near 250 kHz
// R20 - software follows the setup order
// R21 - completed conversion raises waking interrupt
// R22 - software loads factory calibration first
// R23 - calibration in use needs second order
// R24 - converter runs while current source used
// R25 - converter clock = clk/2/(2*div+2)
// R26 - repeat rate = (clk/2)/rate word
// R27 - single result to channel 0, else own
// R28 - unused bits read zero, writes ignored
// R29 - done flag sticky, set beats clear
`timescale 1ns/1ps
`default_nettype none

module aspc_ctrl (
    input  wire logic                       clock,
    input  wire logic                       reset,
    // special-function register port
    input  wire logic [7:0]                 sfr_addr,
    input  wire logic                       sfr_wr,
    input  wire logic                       sfr_rd,
    input  wire logic [7:0]                 sfr_wdata,
    output logic      [7:0]                 sfr_rdata,
    // converter side
    output aspc_pkg::aspc_analog_type       analog_ctrl,
    output aspc_pkg::aspc_conv_req_type     conv_req,
    input  wire logic                       conv_done,
    input  wire logic [11:0]                conv_data,
    output logic                            conversion_irq
);
    import aspc_pkg::*;

    // whole state of the block in one record
    typedef struct packed {
        logic [7:0]           ctrl;
        logic [7:0]           mux_ctrl;
        logic [7:0]           amp_ctrl;
        logic [CAL_DIS_BITS-1:0] cal_dis;
        logic [7:0]           clk_div;
        logic [23:0]          rate;
        logic                 flag;
        logic [3:0][11:0]     result;
        aspc_phase_type       phase;
        logic [1:0]           idx;
        logic                 single;
        logic                 pend;
        logic [DIV_CNT_W-1:0] div_cnt;
        logic [RATE_CNT_W-1:0] rate_cnt;
        logic [7:0]           rdata;
        logic                 start;
        logic [2:0]           chan;
        logic                 tick;
    } aspc_state_type;

    localparam aspc_state_type ST_RESET = '{
        ctrl: RST_BYTE, mux_ctrl: RST_BYTE, amp_ctrl: RST_BYTE, cal_dis: '0,
        clk_div: RST_BYTE, rate: RST_RATE, flag: 1'b0, result: {4{RST_RES}},
        phase: PH_IDLE, idx: 2'd0, single: 1'b0, pend: 1'b0, div_cnt: '0,
        rate_cnt: '0, rdata: RST_BYTE, start: 1'b0, chan: 3'd0, tick: 1'b0};

    aspc_state_type st_q;
    aspc_state_type st_d;

    logic ctrl_wr;
    logic pass_done;
    logic rate_fire;
    logic [DIV_CNT_W-1:0]  div_reload;
    logic [RATE_CNT_W-1:0] rate_reload;

    // register read mux; unmapped offsets answer zero
    function automatic logic [7:0] read_reg(input logic [7:0] a, input aspc_state_type s);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            OFS_CONV_CTRL:   v = s.ctrl;
            OFS_CAL_DISABLE: v = {3'b000, s.cal_dis};
            OFS_CH0_LO:      v = s.result[0][7:0];            // see R16
            OFS_CH0_HI:      v = {4'h0, s.result[0][11:8]};   // see R28
            OFS_CH1_LO:      v = s.result[1][7:0];
            OFS_CH1_HI:      v = {4'h0, s.result[1][11:8]};
            OFS_CH2_LO:      v = s.result[2][7:0];
            OFS_CH2_HI:      v = {4'h0, s.result[2][11:8]};
            OFS_CH3_LO:      v = s.result[3][7:0];
            OFS_CH3_HI:      v = {4'h0, s.result[3][11:8]};
            OFS_STATUS:      v = {7'h00, s.flag};             // see R11
            OFS_RATE_LO:     v = s.rate[7:0];
            OFS_RATE_MID:    v = s.rate[15:8];
            OFS_RATE_HI:     v = s.rate[23:16];
            OFS_AMP_CTRL:    v = s.amp_ctrl;
            OFS_MUX_CTRL:    v = s.mux_ctrl;
            OFS_CLK_DIV:     v = s.clk_div;
            default:         v = 8'h00;
        endcase
        return v;
    endfunction

    // channel handed to the multiplexer for a given step of a pass
    function automatic logic [2:0] pick_channel(input logic single, input logic [2:0] sel,
                                                input logic [1:0] idx);
        // four-channel mode keeps only the top select bit
        return single ? sel : {sel[2], idx};                  // see R5 see R13
    endfunction

    assign ctrl_wr   = sfr_wr && (sfr_addr == OFS_CONV_CTRL);
    // power removed in the done cycle abandons the pass, so the flag stays clear
    assign pass_done = (st_q.phase == PH_WAIT) && conv_done && st_q.ctrl[BIT_PWR_ON] &&
                       (st_q.single || (st_q.idx == 2'd3));
    // period of 4*div+4 cycles: /2 then /(2*div+2)
    assign div_reload  = DIV_CNT_W'(({2'b00, st_q.clk_div} << 2) + 10'd3);          // see R25
    // word 0 would mean infinite rate; treated as timer stopped
    assign rate_reload = RATE_CNT_W'({st_q.rate, 1'b0} - 25'd1);                     // see R26
    assign rate_fire   = st_q.ctrl[BIT_REPEAT] && (st_q.rate != RST_RATE) &&
                         (st_q.rate_cnt == '0);                                      // see R10

    // next-state logic for the whole block
    always_comb begin
        st_d       = st_q;
        st_d.start = 1'b0;
        st_d.tick  = 1'b0;

        // register writes; strobe bits are never stored
        if (sfr_wr) begin
            unique case (sfr_addr)
                OFS_CONV_CTRL:   st_d.ctrl     = sfr_wdata & CTRL_STORE_MASK;  // see R2 see R4 see R9
                OFS_CAL_DISABLE: st_d.cal_dis  = sfr_wdata[CAL_DIS_BITS-1:0];
                OFS_RATE_LO:     st_d.rate[7:0]   = sfr_wdata;                 // see R18
                OFS_RATE_MID:    st_d.rate[15:8]  = sfr_wdata;
                OFS_RATE_HI:     st_d.rate[23:16] = sfr_wdata;
                OFS_AMP_CTRL:    st_d.amp_ctrl = sfr_wdata;                    // see R3
                OFS_MUX_CTRL:    st_d.mux_ctrl = sfr_wdata;                    // see R12 see R15
                OFS_CLK_DIV:     st_d.clk_div  = sfr_wdata;
                default: begin
                    // read-only and unmapped offsets ignore writes
                    st_d.cal_dis = st_q.cal_dis;                               // see R28
                end
            endcase
        end

        // read data is registered, valid the cycle after the strobe
        if (sfr_rd) begin
            st_d.rdata = read_reg(sfr_addr, st_q);
        end

        // converter reference clock enable
        if (st_q.div_cnt == '0) begin
            st_d.div_cnt = div_reload;
            st_d.tick    = st_q.ctrl[BIT_PWR_ON];
        end else begin
            st_d.div_cnt = st_q.div_cnt - 1'b1;
        end

        // repeat timer; reloads while stopped so the first interval is whole
        if (!st_q.ctrl[BIT_REPEAT] || rate_fire) begin
            st_d.rate_cnt = rate_reload;
        end else begin
            st_d.rate_cnt = st_q.rate_cnt - 1'b1;
        end

        // start requests wait here until the sequencer is idle
        if ((ctrl_wr && sfr_wdata[BIT_SINGLE_PASS_START]) || rate_fire) begin
            st_d.pend = 1'b1;                                                  // see R6 see R10
        end

        // pass sequencer
        unique case (st_q.phase)
            PH_IDLE: begin
                if (st_q.pend && st_q.ctrl[BIT_PWR_ON]) begin                  // see R7
                    st_d.pend   = 1'b0;
                    st_d.single = st_q.ctrl[BIT_SINGLE];
                    st_d.idx    = 2'd0;
                    st_d.phase  = PH_ISSUE;
                end else if (!st_q.ctrl[BIT_PWR_ON]) begin
                    // powered-down converter drops queued starts
                    st_d.pend = 1'b0;
                end
            end
            PH_ISSUE: begin
                st_d.start = 1'b1;
                st_d.chan  = pick_channel(st_q.single, st_q.mux_ctrl[POS_SRC_SEL +: 3], st_q.idx);
                st_d.phase = PH_WAIT;
            end
            PH_WAIT: begin
                if (!st_q.ctrl[BIT_PWR_ON]) begin
                    // power removed mid pass: abandon without a result
                    st_d.phase = PH_IDLE;
                end else if (conv_done) begin
                    // single mode always lands in channel 0
                    st_d.result[st_q.single ? 2'd0 : st_q.idx] = conv_data;    // see R17 see R27
                    if (pass_done) begin
                        st_d.phase = PH_IDLE;
                    end else begin
                        st_d.idx   = st_q.idx + 1'b1;
                        st_d.phase = PH_ISSUE;
                    end
                end
            end
        endcase

        // done flag: clear by strobe, but a finishing pass wins
        if (ctrl_wr && sfr_wdata[BIT_IRQ_CLR]) begin
            st_d.flag = 1'b0;                                                  // see R8
        end
        if (pass_done) begin
            st_d.flag = 1'b1;                                                  // see R11 see R29
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge clock) begin
        if (reset) begin
            st_q <= ST_RESET;                                                  // see R1
        end else begin
            st_q <= st_d;
        end
    end

    // outputs toward the analog path and the core
    assign analog_ctrl.reference_gen_enable    = st_q.ctrl[BIT_REF_GEN];
    assign analog_ctrl.gain_amp_enable         = st_q.amp_ctrl[BIT_AMP_EN];
    assign analog_ctrl.gain_amp_trim           = st_q.amp_ctrl[7:1];
    assign analog_ctrl.converter_power_on      = st_q.ctrl[BIT_PWR_ON];
    assign analog_ctrl.reference_source_select = st_q.ctrl[BIT_REF_SRC];
    assign analog_ctrl.correction_order_select = st_q.mux_ctrl[BIT_ORDER];
    assign analog_ctrl.input_buffer_power      = st_q.mux_ctrl[3:0];
    assign analog_ctrl.calibration_disable     = st_q.cal_dis;
    assign conv_req.start    = st_q.start;
    assign conv_req.channel  = st_q.chan;
    assign conv_req.clk_tick = st_q.tick;
    assign sfr_rdata         = st_q.rdata;
    // level interrupt needs no core clock, so it can wake a stopped core
    assign conversion_irq    = st_q.flag && st_q.ctrl[BIT_IRQ_EN];             // see R9 see R21

    // checks on the block's own behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_reset_powered_down: assert property ($fell(reset) |-> !analog_ctrl.reference_gen_enable && !analog_ctrl.gain_amp_enable) // see R1
        else $error("reference or amplifier not powered down after reset");
    a_irq_needs_enable: assert property (conversion_irq |-> st_q.ctrl[BIT_IRQ_EN] && st_q.flag) // see R9
        else $error("interrupt forwarded while gated off");
    a_done_sets_flag: assert property (pass_done |=> st_q.flag && st_q.phase == PH_IDLE) // see R29
        else $error("finished pass did not set the flag");
    a_clear_drops_flag: assert property (ctrl_wr && sfr_wdata[BIT_IRQ_CLR] && !pass_done |=> !st_q.flag) // see R8
        else $error("clear strobe left the flag set");
    a_start_needs_power: assert property (conv_req.start |-> analog_ctrl.converter_power_on) // see R7
        else $error("conversion started while converter powered down");
    a_single_pass_start_starts_pass: assert property (ctrl_wr && sfr_wdata[BIT_SINGLE_PASS_START] && sfr_wdata[BIT_PWR_ON]
            && st_q.phase == PH_IDLE && !pass_done |-> ##3 conv_req.start) // see R6
        else $error("single pass did not start");
    a_single_to_ch0: assert property (st_q.phase == PH_WAIT && conv_done && st_q.single
            && analog_ctrl.converter_power_on |=> st_q.result[0] == $past(conv_data)) // see R27
        else $error("single-channel result not stored in channel 0");
    a_four_chan_select: assert property (conv_req.start && !st_q.single
            |-> conv_req.channel[2] == st_q.mux_ctrl[POS_SRC_SEL+2] && conv_req.channel[1:0] == st_q.idx) // see R13
        else $error("four-channel pass used wrong channel");
    a_tick_spacing: assert property (conv_req.clk_tick |=> !conv_req.clk_tick [*3]) // see R25
        else $error("converter clock enable closer than four cycles");
    a_status_upper_zero: assert property (sfr_rd && sfr_addr == OFS_STATUS |=> sfr_rdata[7:1] == 7'h00) // see R28
        else $error("unused status bits read nonzero");
    a_abort_keeps_flag: assert property (st_q.phase == PH_WAIT && !analog_ctrl.converter_power_on
            && !st_q.flag |=> !st_q.flag) // see R7
        else $error("abandoned pass set the done flag");

    c_single_pass: cover property (pass_done && st_q.single);
    c_four_pass: cover property (pass_done && !st_q.single);
    c_repeat_fire: cover property (rate_fire ##1 st_q.pend);
    c_set_beats_clear: cover property (pass_done && ctrl_wr && sfr_wdata[BIT_IRQ_CLR]);

endmodule

`default_nettype wire

/* File: aspc_pkg.sv */
// package for the converter signal path control: register map, fields, state, carriers
package aspc_pkg;

    // register offsets on the special-function register bus
    localparam logic [7:0] OFS_CONV_CTRL   = 8'h94;
    localparam logic [7:0] OFS_CAL_DISABLE = 8'h96;
    localparam logic [7:0] OFS_CH0_LO      = 8'ha4;
    localparam logic [7:0] OFS_CH0_HI      = 8'ha5;
    localparam logic [7:0] OFS_CH1_LO      = 8'ha6;
    localparam logic [7:0] OFS_CH1_HI      = 8'ha7;
    localparam logic [7:0] OFS_CH2_LO      = 8'hac;
    localparam logic [7:0] OFS_CH2_HI      = 8'had;
    localparam logic [7:0] OFS_CH3_LO      = 8'hae;
    localparam logic [7:0] OFS_CH3_HI      = 8'haf;
    localparam logic [7:0] OFS_STATUS      = 8'hbc;
    localparam logic [7:0] OFS_RATE_LO     = 8'hf5;
    localparam logic [7:0] OFS_RATE_MID    = 8'hf6;
    localparam logic [7:0] OFS_RATE_HI     = 8'hf7;
    localparam logic [7:0] OFS_AMP_CTRL    = 8'hf9;
    localparam logic [7:0] OFS_MUX_CTRL    = 8'hfc;
    localparam logic [7:0] OFS_CLK_DIV     = 8'hfe;

    // converter_control bit positions
    localparam int BIT_REF_SRC   = 7;
    localparam int BIT_SINGLE    = 6;
    localparam int BIT_SINGLE_PASS_START   = 5;
    localparam int BIT_PWR_ON    = 4;
    localparam int BIT_IRQ_CLR   = 3;
    localparam int BIT_IRQ_EN    = 2;
    localparam int BIT_REPEAT    = 1;
    localparam int BIT_REF_GEN   = 0;
    // strobe bits are not stored and read as zero
    localparam logic [7:0] CTRL_STORE_MASK = 8'hd7;
    // input_mux_control fields, amplifier enable bit and calibration disable width
    localparam int BIT_ORDER     = 7;
    localparam int POS_SRC_SEL   = 4;
    localparam int BIT_AMP_EN    = 0;
    localparam int CAL_DIS_BITS  = 5;

    // values after reset: every power control starts powered down
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [23:0] RST_RATE  = 24'h000000;
    localparam logic [11:0] RST_RES   = 12'h000;

    // timing: converter clock = clk / 2 / (2*div + 2), rate = (clk / 2) / word
    localparam int CLK_MHZ        = 250;
    localparam int REF_DIV_FACTOR = 2;
    localparam int RATE_FACTOR    = 2;
    localparam int DIV_CNT_W      = 10;
    localparam int RATE_CNT_W     = 25;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ISSUE,
        PH_WAIT
    } aspc_phase_type;

    // controls toward the analog path
    typedef struct packed {
        logic       reference_gen_enable;
        logic       gain_amp_enable;
        logic [6:0] gain_amp_trim;
        logic       converter_power_on;
        logic       reference_source_select;
        logic       correction_order_select;
        logic [3:0] input_buffer_power;
        logic [4:0] calibration_disable;
    } aspc_analog_type;

    // one conversion request toward the converter
    typedef struct packed {
        logic       start;
        logic [2:0] channel;
        logic       clk_tick;
    } aspc_conv_req_type;

endpackage

/* File: tb_adc_signal_path_control.sv */
// testbench for the converter signal path control block
`timescale 1ns/1ps
`default_nettype none

module tb_adc_signal_path_control;
    import aspc_pkg::*;

    logic              clock = 1'b0;
    logic              reset = 1'b1;
    logic [7:0]        sfr_addr = 8'h00;
    logic              sfr_wr = 1'b0;
    logic              sfr_rd = 1'b0;
    logic [7:0]        sfr_wdata = 8'h00;
    logic [7:0]        sfr_rdata;
    aspc_analog_type   analog_ctrl;
    aspc_conv_req_type conv_req;
    logic              conv_done;
    logic [11:0]       conv_data;
    logic              conversion_irq;
    logic [3:0]        lat = 4'h1;
    logic [11:0]       base = 12'h3c0;
    int                bad_count = 0;
    int                n_compared = 0;
    logic [2:0]        starts[$];
    time               stimes[$];
    time               tick_a = 0;
    time               tick_b = 0;
    logic [7:0]        rv;
    localparam logic [7:0] RST_OFS[18] = '{8'h94, 8'h96, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'hac, 8'had, 8'hae,
                                            8'haf, 8'hbc, 8'hf5, 8'hf6, 8'hf7, 8'hf9, 8'hfc, 8'hfe, 8'h00};
    localparam logic [7:0] RES_LO[4] = '{8'ha4, 8'ha6, 8'hac, 8'hae};

    always #2 clock = ~clock;

    aspc_ctrl u_dut (
        .clock          (clock),
        .reset          (reset),
        .sfr_addr       (sfr_addr),
        .sfr_wr         (sfr_wr),
        .sfr_rd         (sfr_rd),
        .sfr_wdata      (sfr_wdata),
        .sfr_rdata      (sfr_rdata),
        .analog_ctrl    (analog_ctrl),
        .conv_req       (conv_req),
        .conv_done      (conv_done),
        .conv_data      (conv_data),
        .conversion_irq (conversion_irq)
    );

    aspc_conv_model u_conv (
        .clock     (clock),
        .reset     (reset),
        .conv_req  (conv_req),
        .lat       (lat),
        .base      (base),
        .conv_done (conv_done),
        .conv_data (conv_data)
    );

    // record every start and tick so timing is judged from edges, not polling
    always @(posedge clock) begin
        if (conv_req.start) begin
            starts.push_back(conv_req.channel);
            if (conv_req.channel[1:0] == 2'b00) stimes.push_back($time);
        end
        if (conv_req.clk_tick) begin
            tick_a = tick_b;
            tick_b = $time;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_wr    <= 1'b1;
        sfr_addr  <= a;
        sfr_wdata <= d;
        @(posedge clock);
        sfr_wr <= 1'b0;
        // step past the edge so callers see the updated registers
        #1;
    endtask

    // read data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        sfr_rd   <= 1'b1;
        sfr_addr <= a;
        @(posedge clock);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #40000;
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        #1 chk(analog_ctrl, '0);
        foreach (RST_OFS[i]) begin
            rd(RST_OFS[i], rv);
            chk(rv, 8'h00);
        end
        // control bits: strobes read as zero, stored levels reach the analog side
        wr(8'h94, 8'h9d);
        rd(8'h94, rv);
        chk(rv, 8'h95);
        chk(analog_ctrl.reference_gen_enable, 1'b1);
        chk(analog_ctrl.reference_source_select, 1'b1);
        chk(analog_ctrl.converter_power_on, 1'b1);
        wr(8'hf9, 8'h81);
        chk({analog_ctrl.gain_amp_enable, analog_ctrl.gain_amp_trim}, 8'hc0);
        wr(8'hfc, 8'hda);
        chk(analog_ctrl.correction_order_select, 1'b1);
        chk(analog_ctrl.input_buffer_power, 4'ha);
        wr(8'hf5, 8'h28);
        wr(8'hf6, 8'h5a);
        wr(8'hf7, 8'ha5);
        rd(8'hf5, rv);
        chk(rv, 8'h28);
        rd(8'hf6, rv);
        chk(rv, 8'h5a);
        rd(8'hf7, rv);
        chk(rv, 8'ha5);
        // calibration disable keeps five bits, the rest read zero
        wr(8'h96, 8'hff);
        rd(8'h96, rv);
        chk(rv, 8'h1f);
        chk(analog_ctrl.calibration_disable, 5'h1f);
        wr(8'hbc, 8'hff);
        rd(8'hbc, rv);
        chk(rv, 8'h00);
        // single pass on select 5, result lands in channel 0
        wr(8'h94, 8'h75);
        for (int i = 0; i < 60 && conversion_irq !== 1'b1; i++) @(posedge clock);
        chk(conversion_irq, 1'b1);
        chk(starts.size(), 1);
        chk(starts[0], 3'h5);
        rd(8'hbc, rv);
        chk(rv, 8'h01);
        rd(8'ha4, rv);
        chk(rv, 8'hc5);
        rd(8'ha5, rv);
        chk(rv, 8'h03);
        wr(8'h94, 8'h5d);
        rd(8'hbc, rv);
        chk(rv, 8'h00);
        chk(conversion_irq, 1'b0);
        // four channel pass, slow converter, low select bits must not matter
        starts = {};
        lat  <= 4'h6;
        base <= 12'h7a0;
        wr(8'hfc, 8'hff);
        wr(8'h94, 8'h31);
        rv = 8'h00;
        for (int i = 0; i < 30 && rv !== 8'h01; i++) rd(8'hbc, rv);
        chk(conversion_irq, 1'b0);
        chk(starts.size(), 4);
        foreach (RES_LO[n]) begin
            chk(starts[n], 3'h4 + 3'(n));
            rd(RES_LO[n], rv);
            chk(rv, 8'ha4 + 8'(n));
            rd(RES_LO[n] + 8'h01, rv);
            chk(rv, 8'h07);
        end
        // power removed mid pass abandons it; a start while powered down is dropped
        starts = {};
        wr(8'h94, 8'h78);
        repeat (3) @(posedge clock);
        wr(8'h94, 8'h20);
        repeat (20) @(posedge clock);
        chk(starts.size(), 1);
        rd(8'hbc, rv);
        chk(rv, 8'h00);
        rd(8'ha4, rv);
        chk(rv, 8'ha4);
        // converter clock tick every 4*div+4 cycles
        // divisor nearest a 250 kHz reference at a 250 MHz clock
        wr(8'hfe, 8'hf9);
        wr(8'h94, 8'h10);
        repeat (2100) @(posedge clock);
        chk(32'(tick_b - tick_a), 32'd4000);
        // repeat passes every 2*rate cycles with a 40 rate word
        lat <= 4'h1;
        wr(8'hf6, 8'h00);
        wr(8'hf7, 8'h00);
        stimes = {};
        wr(8'h94, 8'h13);
        wr(8'h94, 8'h1f);
        repeat (300) @(posedge clock);
        chk(stimes.size() >= 3, 1'b1);
        if (stimes.size() >= 3) chk(32'(stimes[2] - stimes[1]), 32'd320);
        chk(conversion_irq, 1'b1);
        wr(8'h94, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
